//--- verilog/stsq_defs.vh
// Constants for the self-test sequencer and lamp driver
`ifndef STSQ_DEFS_VH
`define STSQ_DEFS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define STSQ_CLK_HZ 50000000
`define STSQ_LAMP_MS 2000
`define STSQ_LAMP_CYC ((`STSQ_CLK_HZ / 1000) * `STSQ_LAMP_MS)
// ----------------------------------------
// Test numbering
// ----------------------------------------
`define STSQ_FIRST_TEST 4'h1
`define STSQ_LAST_TEST 4'hE
`define STSQ_KEY_TEST 4'hE
`define STSQ_NVM_TEST 4'hC
`define STSQ_DEFAULT_COND 4'hF
`define STSQ_SEL_ONCE 5'h11
`define STSQ_SEL_LOOP 5'h12
`define STSQ_NVM_LIMIT 16'h0014
// ----------------------------------------
// Lamp reset values
// ----------------------------------------
`define STSQ_FRONT_ALL 8'hFF
`define STSQ_BOARD_ALL 6'h3F
`endif

//--- verilog/stsq_sequencer.v
// Self-test sequencer with front-panel and board lamp reporting
`include "stsq_defs.vh"
`default_nettype none
// ----------------------------------------
// Behaviour notes
// ----------------------------------------
// The sequencer never runs a test itself. It only hands out start pulses
// and test numbers, then waits for the far side to answer with done and
// an optional failure flag plus subtest code.
// The subtest code is trusted only together with the failure flag. A test
// that is failed here on purpose (keypad held) reports no subtest.
// The board lamp timer is shared by the power-up display and the failure
// display. It must be wide enough for a two-second hold at the full
// processor clock, which takes 27 bits.
// Single-test repeat mode does not touch the front lamps when a test
// starts, so a failure stays latched until a full sequence is started.
// The repeat mode may be left at any point of the test cycle, not only
// while a result is awaited, so a one-cycle key pulse is never lost.
// A clean sequence ends with the keypad test number on the front lamps,
// so an operator sees the same code whichever way the run finished.
module stsq_sequencer #(
  parameter LAMP_CYC = `STSQ_LAMP_CYC // Two-second board lamp hold, in cycles
) (
  input wire clk_i, // Processor clock
  input wire rst_n_i, // Power-on reset, active low
  input wire diag_btn_i, // Recessed diagnostic button, high while held
  input wire key_held_i, // Any keypad key held down
  input wire menu_enter_key_i, // Menu enter key, one-cycle pulse
  input wire entry_key_i, // Any numeric entry key, one-cycle pulse
  input wire [4:0] menu_sel_i, // Number entered before the enter key
  input wire test_done_i, // Current test finished, one-cycle pulse
  input wire test_fail_i, // With done: test failed
  input wire [3:0] sub_num_i, // With done: failing subtest number
  input wire proc_err_i, // Processor error, one-cycle pulse
  input wire copy_done_i, // Program copy into working memory finished
  output reg test_start_o, // Start the test in test_num_o, one-cycle pulse
  output reg [3:0] test_num_o, // Test being run
  output reg nvm_write_en_o, // Memory write check allowed in this run
  output reg copy_start_o, // Start copying the program, one-cycle pulse
  output reg run_program_o, // Control handed to the copied program
  output reg menu_active_o, // Test menu open
  output reg [7:0] front_lamp_o, // Upper four lamps [7:4], weighted 8-4-2-1 [3:0]
  output reg [5:0] board_lamp_o, // Board lamps weighted 32 down to 1
  output reg [15:0] pass_count_o, // Loop passes
  output reg [15:0] fail_count_o, // Loop failures
  output reg [3:0] last_fail_test_o, // Test of most recent loop failure
  output reg [3:0] last_fail_sub_o // Subtest of most recent loop failure
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_POWER = 3'h0; // Power-up board lamp display
  localparam [2:0] ST_HOLD = 3'h1; // Button held, all front lamps lit, board lamps left as they were
  localparam [2:0] ST_START = 3'h2; // Issue start of current test
  localparam [2:0] ST_WAIT = 3'h3; // Await result of current test
  localparam [2:0] ST_FAIL = 3'h4; // Halted on failure
  localparam [2:0] ST_COPY = 3'h5; // Copy program to working memory
  localparam [2:0] ST_RUN = 3'h6; // Operating program running
  localparam [2:0] ST_IDLE = 3'h7; // Menu open, nothing running
  // Run modes
  localparam [1:0] MD_ONCE = 2'h0; // Sequence once then load program
  localparam [1:0] MD_MENU = 2'h1; // Sequence once from the menu
  localparam [1:0] MD_LOOP = 2'h2; // Endless sequence loop
  localparam [1:0] MD_SINGLE = 2'h3; // One test repeated

  reg [2:0] state; // Sequencer state
  reg [1:0] mode; // Current run mode
  reg [26:0] lamp_timer; // Board lamp hold counter, holds two seconds at full clock
  reg board_sub_pend; // Subtest still to be shown on board lamps
  reg [3:0] fail_sub; // Subtest of last failure
  reg key_stuck; // Key was held at sequence start
  reg [15:0] loop_count; // Loop iterations done
  reg btn_q; // Button last cycle

  // Next test in the fixed order: keypad test is run right after test 2
  function [3:0] next_test;
    input [3:0] cur;
    begin
      case (cur)
        4'h2: next_test = `STSQ_KEY_TEST;
        4'hE: next_test = 4'h3;
        4'hD: next_test = 4'h0;
        default: next_test = cur + 4'h1;
      endcase
    end
  endfunction

  // Board lamp code for a test, condition 15 never shown
  function [5:0] board_code;
    input [3:0] num;
    begin
      if (num == `STSQ_DEFAULT_COND) begin
        board_code = 6'h00;
      end else begin
        board_code = {2'b00, num};
      end
    end
  endfunction

  // ----------------------------------------
  // Edge detection and result decode
  // ----------------------------------------
  wire btn_press = diag_btn_i & ~btn_q; // Button press edge
  wire btn_release = ~diag_btn_i & btn_q; // Button release edge
  wire running = (state == ST_START) || (state == ST_WAIT);
  // A held key forces the keypad test to fail
  wire eff_fail = test_fail_i | (key_stuck & (test_num_o == `STSQ_KEY_TEST));
  wire [3:0] upcoming = next_test(test_num_o);
  // Subtest code counts only when the test itself reported failure
  wire [3:0] fail_code = test_fail_i ? sub_num_i : 4'h0;
  // Leaving single-test repeat: processor error or any entry key
  wire single_exit = (mode == MD_SINGLE) && (proc_err_i || entry_key_i);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Main state machine; all lamp outputs are registered
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_POWER;
      mode <= MD_ONCE;
      lamp_timer <= 27'h0000000;
      board_sub_pend <= 1'b0;
      fail_sub <= 4'h0;
      key_stuck <= 1'b0;
      loop_count <= 16'h0000;
      btn_q <= 1'b0;
      test_start_o <= 1'b0;
      test_num_o <= `STSQ_FIRST_TEST;
      nvm_write_en_o <= 1'b0;
      copy_start_o <= 1'b0;
      run_program_o <= 1'b0;
      menu_active_o <= 1'b0;
      front_lamp_o <= `STSQ_FRONT_ALL;
      board_lamp_o <= `STSQ_BOARD_ALL;
      pass_count_o <= 16'h0000;
      fail_count_o <= 16'h0000;
      last_fail_test_o <= 4'h0;
      last_fail_sub_o <= 4'h0;
    end else begin
      btn_q <= diag_btn_i;
      test_start_o <= 1'b0;
      copy_start_o <= 1'b0;
      // Board lamp timer: test number first, subtest after two seconds
      // Counts down to zero; the last step swaps test code for subtest code
      if (lamp_timer != 27'h0000000) begin
        lamp_timer <= lamp_timer - 27'h0000001;
        if (lamp_timer == 27'h0000001 && board_sub_pend) begin
          board_lamp_o <= {2'b00, fail_sub};
          board_sub_pend <= 1'b0;
        end
      end
      if (diag_btn_i && state != ST_POWER) begin
        // Button held: terminate whatever runs, light all front lamps
        state <= ST_HOLD;
        front_lamp_o <= `STSQ_FRONT_ALL;
        run_program_o <= 1'b0;
        menu_active_o <= 1'b0;
      end else begin
        case (state)
          ST_POWER: begin
            // Hold board lamps lit, then start the sequence
            // First cycle out of reset: arm the two-second hold once
            if (lamp_timer == 27'h0000000 && !board_sub_pend) begin
              if (board_lamp_o == `STSQ_BOARD_ALL && front_lamp_o == `STSQ_FRONT_ALL
                  && test_num_o == `STSQ_FIRST_TEST && !key_stuck && mode == MD_ONCE
                  && loop_count == 16'h0000 && !nvm_write_en_o && !copy_start_o) begin
                lamp_timer <= LAMP_CYC[26:0] - 27'h0000001;
                key_stuck <= key_held_i;
                nvm_write_en_o <= 1'b1;
              end
            end
            // Hold over: dark lamps mark the start of the sequence
            if (lamp_timer == 27'h0000001) begin
              board_lamp_o <= 6'h00;
              front_lamp_o <= 8'h00;
              state <= ST_START;
            end
          end
          ST_HOLD: begin
            if (btn_release) begin
              front_lamp_o <= 8'h00;
              key_stuck <= key_held_i;
              mode <= MD_ONCE;
              test_num_o <= `STSQ_FIRST_TEST;
              nvm_write_en_o <= 1'b1;
              state <= ST_START;
            end
          end
          ST_START: begin
            if (single_exit) begin
              // A key pulse between two repeats still ends the loop
              state <= ST_IDLE;
              menu_active_o <= 1'b1;
            end else begin
              // Issue the start pulse for the current test
              test_start_o <= 1'b1;
              // Repeat mode keeps a latched failure on the front lamps
              if (mode != MD_SINGLE) begin
                front_lamp_o <= {4'h0, test_num_o};
              end
              state <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (single_exit) begin
              // Repeat mode leaves on error or an entry key, or when the button is held
              state <= ST_IDLE;
              menu_active_o <= 1'b1;
            end else if (test_done_i && eff_fail) begin
              fail_sub <= fail_code;
              // Failed test number, upper lamps dark
              if (test_num_o == `STSQ_FIRST_TEST || fail_code == 4'h0) begin
                front_lamp_o <= {4'h0, test_num_o};
              end else begin
                // One upper lamp lit marks a subtest code
                front_lamp_o <= {4'h1, fail_code};
              end
              board_lamp_o <= board_code(test_num_o);
              lamp_timer <= LAMP_CYC[26:0];
              board_sub_pend <= (test_num_o != `STSQ_FIRST_TEST);
              if (mode == MD_LOOP) begin
                fail_count_o <= fail_count_o + 16'h0001;
                last_fail_test_o <= test_num_o;
                last_fail_sub_o <= fail_code;
                test_num_o <= `STSQ_FIRST_TEST;
                loop_count <= loop_count + 16'h0001;
                nvm_write_en_o <= (loop_count + 16'h0001) < `STSQ_NVM_LIMIT;
                state <= ST_START;
              end else if (mode == MD_SINGLE) begin
                state <= ST_START;
              end else begin
                state <= ST_FAIL;
              end
            end else if (test_done_i) begin
              // Passed: pick the next step by run mode
              if (mode == MD_SINGLE) begin
                loop_count <= loop_count + 16'h0001;
                nvm_write_en_o <= (loop_count + 16'h0001) < `STSQ_NVM_LIMIT;
                state <= ST_START;
              end else if (upcoming != 4'h0) begin
                test_num_o <= upcoming;
                state <= ST_START;
              end else if (mode == MD_LOOP) begin
                pass_count_o <= pass_count_o + 16'h0001;
                test_num_o <= `STSQ_FIRST_TEST;
                loop_count <= loop_count + 16'h0001;
                nvm_write_en_o <= (loop_count + 16'h0001) < `STSQ_NVM_LIMIT;
                state <= ST_START;
              end else if (mode == MD_MENU || key_stuck) begin
                // Whole sequence passed: keypad test code is left lit
                front_lamp_o <= {4'h0, `STSQ_KEY_TEST};
                state <= ST_IDLE;
                menu_active_o <= 1'b1;
              end else begin
                // Whole sequence passed: keypad test code is left lit
                front_lamp_o <= {4'h0, `STSQ_KEY_TEST};
                copy_start_o <= 1'b1;
                state <= ST_COPY;
              end
            end
          end
          ST_FAIL: begin
            // Stay halted; the menu enter key opens the test menu
            if (menu_enter_key_i) begin
              menu_active_o <= 1'b1;
              state <= ST_IDLE;
            end
          end
          ST_COPY: begin
            if (copy_done_i) begin
              run_program_o <= 1'b1;
              state <= ST_RUN;
            end
          end
          ST_RUN: begin
            // Program owns the unit; only the button leaves this state
            state <= ST_RUN;
          end
          ST_IDLE: begin
            // Menu open: the enter key starts the selection entered
            if (menu_enter_key_i) begin
              menu_active_o <= 1'b0;
              key_stuck <= 1'b0;
              loop_count <= 16'h0000;
              nvm_write_en_o <= 1'b1;
              state <= ST_START;
              if (menu_sel_i == `STSQ_SEL_ONCE) begin
                mode <= MD_MENU;
                test_num_o <= `STSQ_FIRST_TEST;
                front_lamp_o <= 8'h00;
              end else if (menu_sel_i == `STSQ_SEL_LOOP) begin
                mode <= MD_LOOP;
                test_num_o <= `STSQ_FIRST_TEST;
                pass_count_o <= 16'h0000;
                fail_count_o <= 16'h0000;
                front_lamp_o <= 8'h00;
              end else if (menu_sel_i >= 5'h01 && menu_sel_i <= 5'h0E) begin
                mode <= MD_SINGLE;
                test_num_o <= menu_sel_i[3:0];
              end else begin
                // Unknown selection: stay in the menu
                menu_active_o <= 1'b1;
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            // Unused code: restart from the power-up display
            state <= ST_POWER;
          end
        endcase
      end
      // A press during the power-up display still wins over it
      if (btn_press && state == ST_POWER) begin
        state <= ST_HOLD;
        front_lamp_o <= `STSQ_FRONT_ALL;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/stsq_test_model.sv
// Far-side test engine model: answers test starts and program copy requests
`default_nettype none
module stsq_test_model (
  input wire logic clk_i, // Processor clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic test_start_i, // Start pulse from the sequencer
  input wire logic [3:0] test_num_i, // Test to run
  input wire logic [3:0] fail_num_i, // Test that fails, 0 for none
  input wire logic [3:0] fail_sub_i, // Subtest reported on failure
  input wire logic copy_start_i, // Program copy request
  output logic test_done_o, // Result pulse
  output logic test_fail_o, // Failure flag, valid with done
  output logic [3:0] sub_num_o, // Subtest number, valid with done
  output logic copy_done_o // Copy finished pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] t_dly; // Test run time left
  logic [1:0] c_dly; // Copy time left
  // --------------------------------
  // Answer two edges after each start; invalid data toggles between answers
  // --------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_dly <= 2'h0;
      c_dly <= 2'h0;
      test_done_o <= 1'b0;
      test_fail_o <= 1'b0;
      sub_num_o <= 4'h0;
      copy_done_o <= 1'b0;
    end else begin
      test_done_o <= t_dly == 2'h1;
      test_fail_o <= t_dly == 2'h1 && test_num_i == fail_num_i;
      sub_num_o <= (t_dly == 2'h1) ? fail_sub_i : ~sub_num_o;
      copy_done_o <= c_dly == 2'h1;
      t_dly <= test_start_i ? 2'h2 : (t_dly != 2'h0 ? t_dly - 2'h1 : 2'h0);
      c_dly <= copy_start_i ? 2'h3 : (c_dly != 2'h0 ? c_dly - 2'h1 : 2'h0);
    end
  end
endmodule
`default_nettype wire

//--- test/stsq_sequencer_checker.sv
// Concurrent checks on the sequencer ports
`default_nettype none
module stsq_sequencer_checker #(
  parameter int LAMP_CYC = 20 // Board lamp hold, in cycles
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic diag_btn_i,
  input wire logic menu_enter_key_i,
  input wire logic [4:0] menu_sel_i,
  input wire logic menu_active_o,
  input wire logic test_done_i,
  input wire logic test_fail_i,
  input wire logic [3:0] sub_num_i,
  input wire logic test_start_o,
  input wire logic [3:0] test_num_o,
  input wire logic copy_start_o,
  input wire logic run_program_o,
  input wire logic nvm_write_en_o,
  input wire logic [7:0] front_lamp_o,
  input wire logic [5:0] board_lamp_o,
  input wire logic [15:0] pass_count_o,
  input wire logic [15:0] fail_count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  int cyc; // Cycles since reset, saturating
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cyc <= 0;
    else if (cyc < LAMP_CYC) cyc <= cyc + 1;
  end
  logic single_md; // Single-test repeat chosen in the menu
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) single_md <= 1'b0;
    else if (diag_btn_i) single_md <= 1'b0;
    else if (menu_enter_key_i && menu_active_o)
      single_md <= menu_sel_i >= 5'h01 && menu_sel_i <= 5'h0E;
  end
  chk_btn_all_on: assert property (
    diag_btn_i [*3] |-> front_lamp_o == 8'hFF) else $error("button held, lamps not all on");
  chk_release_clears: assert property (
    $fell(diag_btn_i) |-> ##[1:3] front_lamp_o == 8'h00) else $error("release left lamps on");
  chk_start_shows_num: assert property (
    test_start_o && !single_md |-> front_lamp_o == {4'h0, test_num_o})
    else $error("test number not shown");
  chk_copy_at_end: assert property (
    copy_start_o |-> front_lamp_o == 8'h0E && !run_program_o) else $error("copy started early");
  chk_board_no_15: assert property (
    board_lamp_o != 6'h0F) else $error("board lamps show code 15");
  chk_power_board: assert property (
    cyc < LAMP_CYC - 1 |-> board_lamp_o == 6'h3F) else $error("power-up board lamps short");
  chk_sub_report: assert property (test_done_i && test_fail_i && sub_num_i != 4'h0
    && test_num_o != 4'h1 && pass_count_o == 16'h0000 && fail_count_o == 16'h0000
    |=> front_lamp_o == {4'h1, $past(sub_num_i)} && board_lamp_o == {2'b00, $past(test_num_o)})
    else $error("subtest failure lamps wrong");
  chk_fail_count: assert property (
    $changed(fail_count_o) |-> fail_count_o == $past(fail_count_o) + 16'h0001)
    else $error("failure count stepped wrongly");
  chk_nvm_limit: assert property (
    pass_count_o >= 16'h0014 |-> ##[0:3] !nvm_write_en_o) else $error("write check past limit");
  cover property (copy_start_o);
  cover property (front_lamp_o[7:4] == 4'h1);
  cover property (pass_count_o == 16'h0014);
endmodule
bind stsq_sequencer stsq_sequencer_checker #(.LAMP_CYC(LAMP_CYC)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .diag_btn_i(diag_btn_i), .test_done_i(test_done_i),
  .menu_enter_key_i(menu_enter_key_i), .menu_sel_i(menu_sel_i), .menu_active_o(menu_active_o),
  .test_fail_i(test_fail_i), .sub_num_i(sub_num_i), .test_start_o(test_start_o),
  .test_num_o(test_num_o), .copy_start_o(copy_start_o), .run_program_o(run_program_o),
  .nvm_write_en_o(nvm_write_en_o), .front_lamp_o(front_lamp_o), .board_lamp_o(board_lamp_o),
  .pass_count_o(pass_count_o), .fail_count_o(fail_count_o));
`default_nettype wire

//--- test/test_stsq_sequencer.sv
// Self-checking bench for the self-test sequencer
`default_nettype none
module test_stsq_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LC = 20; // Short board lamp hold
  logic clk_i = 0, rst_n_i = 0, diag_btn_i = 0, key_held_i = 0, menu_enter_key_i = 0;
  logic entry_key_i = 0, proc_err_i = 0; // Repeat-mode exits
  logic [4:0] menu_sel_i = 5'h00;
  logic [3:0] fail_num = 4'h0, fail_sub = 4'h0; // Model failure setup
  logic test_done_i, test_fail_i, copy_done_i, test_start_o, nvm_write_en_o;
  logic copy_start_o, run_program_o, menu_active_o;
  logic [3:0] sub_num_i, test_num_o, last_fail_test_o, last_fail_sub_o;
  logic [7:0] front_lamp_o;
  logic [5:0] board_lamp_o;
  logic [15:0] pass_count_o, fail_count_o, snap;
  int fail_count = 0, n_checks = 0, t;
  logic [3:0] ord [14] = '{4'h1, 4'h2, 4'hE, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
    4'hA, 4'hB, 4'hC, 4'hD}; // Expected test order
  stsq_sequencer #(.LAMP_CYC(LC)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .diag_btn_i(diag_btn_i), .key_held_i(key_held_i), .menu_enter_key_i(menu_enter_key_i),
    .entry_key_i(entry_key_i), .menu_sel_i(menu_sel_i), .test_done_i(test_done_i),
    .test_fail_i(test_fail_i), .sub_num_i(sub_num_i), .proc_err_i(proc_err_i),
    .copy_done_i(copy_done_i), .test_start_o(test_start_o), .test_num_o(test_num_o),
    .nvm_write_en_o(nvm_write_en_o), .copy_start_o(copy_start_o),
    .run_program_o(run_program_o), .menu_active_o(menu_active_o),
    .front_lamp_o(front_lamp_o), .board_lamp_o(board_lamp_o), .pass_count_o(pass_count_o),
    .fail_count_o(fail_count_o), .last_fail_test_o(last_fail_test_o),
    .last_fail_sub_o(last_fail_sub_o));
  stsq_test_model u_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .test_start_i(test_start_o),
    .test_num_i(test_num_o), .fail_num_i(fail_num), .fail_sub_i(fail_sub),
    .copy_start_i(copy_start_o), .test_done_o(test_done_i), .test_fail_o(test_fail_i),
    .sub_num_o(sub_num_i), .copy_done_o(copy_done_i));
  initial forever #10 clk_i = ~clk_i; // 50 MHz
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] pick(input int w);
    case (w)
      0: pick = {8'h00, front_lamp_o};
      1: pick = {10'h000, board_lamp_o};
      2: pick = pass_count_o;
      default: pick = fail_count_o;
    endcase
  endfunction
  // Bounded wait for a lamp or counter value
  task wait_val(input int w, input logic [15:0] v);
    int k;
    for (k = 0; k < 4000 && pick(w) !== v; k++) @(negedge clk_i);
    check(pick(w), v);
    if (k == 4000) test_done;
  endtask
  // Follows one full sequence of test starts
  task run_order;
    int k, n;
    n = 0;
    for (k = 0; k < 2000 && n < 14; k++) begin
      @(negedge clk_i);
      if (test_start_o === 1'b1) begin
        check(test_num_o, ord[n]);
        n++;
      end
    end
    if (n < 14) begin
      fail_count++;
      test_done;
    end
  endtask
  task enter(input logic [4:0] sel);
    menu_sel_i = sel;
    menu_enter_key_i = 1;
    @(negedge clk_i);
    menu_enter_key_i = 0;
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (12) @(negedge clk_i);
    check(front_lamp_o, 8'hFF);
    check(board_lamp_o, 6'h3F);
    rst_n_i = 1;
    repeat (LC - 4) @(negedge clk_i);
    check(board_lamp_o, 6'h3F);
    run_order;
    for (t = 0; t < 60 && run_program_o !== 1'b1; t++) @(negedge clk_i);
    check(run_program_o, 1'b1);
    fail_num = 4'h5;
    fail_sub = 4'h3;
    diag_btn_i = 1;
    repeat (3) @(negedge clk_i);
    check(front_lamp_o, 8'hFF);
    diag_btn_i = 0;
    wait_val(0, 16'h0000);
    wait_val(0, 16'h0013);
    check(board_lamp_o, 6'h05);
    wait_val(1, 16'h0003);
    repeat (40) @(negedge clk_i);
    check(front_lamp_o, 8'h13);
    fail_num = 4'h0;
    key_held_i = 1;
    diag_btn_i = 1;
    @(negedge clk_i);
    diag_btn_i = 0;
    wait_val(0, 16'h000E);
    repeat (20) @(negedge clk_i);
    check(front_lamp_o, 8'h0E);
    key_held_i = 0;
    enter(5'h00);
    check(menu_active_o, 1'b1);
    enter(5'h11);
    run_order;
    repeat (20) @(negedge clk_i);
    check(menu_active_o, 1'b1);
    fail_num = 4'h6;
    fail_sub = 4'h2;
    enter(5'h06);
    wait_val(0, 16'h0012);
    fail_num = 4'h0;
    repeat (20) @(negedge clk_i);
    check(front_lamp_o, 8'h12);
    entry_key_i = 1;
    @(negedge clk_i);
    entry_key_i = 0;
    repeat (2) @(negedge clk_i);
    check(menu_active_o, 1'b1);
    check(front_lamp_o, 8'h12);
    enter(5'h12);
    repeat (3) @(negedge clk_i);
    check(nvm_write_en_o, 1'b1);
    wait_val(2, 16'h0014);
    repeat (4) @(negedge clk_i);
    check(nvm_write_en_o, 1'b0);
    check(fail_count_o, 16'h0000);
    fail_num = 4'h6;
    fail_sub = 4'h2;
    wait_val(3, 16'h0001);
    check(last_fail_test_o, 4'h6);
    check(last_fail_sub_o, 4'h2);
    diag_btn_i = 1;
    repeat (2) @(negedge clk_i);
    snap = pass_count_o;
    repeat (100) @(negedge clk_i);
    check(pass_count_o, snap);
    test_done;
  end
endmodule
`default_nettype wire
